/* File: verilog/opcode_pkg.sv */
// package: opcodes, word fields, cycle budgets and bus offsets for the opcode decoder
package opcode_pkg;

  typedef enum logic [6:0] {
    OP_NONE            = 7'h00,
    OP_NOP             = 7'h01,
    OP_STRING_CUR      = 7'h02,
    OP_ARC_CUR         = 7'h03,
    OP_CIRCLE_CUR      = 7'h04,
    OP_LINE_CUR        = 7'h05,
    OP_POINT_CUR       = 7'h06,
    OP_FRECT_CUR       = 7'h07,
    OP_FTRI_CUR        = 7'h08,
    OP_FBOUND_CUR      = 7'h09,
    OP_FCONN_CUR       = 7'h0a,
    OP_BIN_CUR         = 7'h0b,
    OP_BOUT_CUR        = 7'h0c,
    OP_BCOPY_CUR       = 7'h0d,
    OP_BXFORM_CUR      = 7'h0e,
    OP_SET_COLOR       = 7'h0f,
    OP_SET_SEARCH      = 7'h10,
    OP_SET_BLOCK       = 7'h11,
    OP_FONT_CUR        = 7'h12,
    OP_CLIP_BND_CUR    = 7'h13,
    OP_LINE_STYLE      = 7'h14,
    OP_STYLE_PHASE     = 7'h15,
    OP_VIEWPORT_CUR    = 7'h16,
    OP_PICK_REG_CUR    = 7'h17,
    OP_SCALE           = 7'h18,
    OP_PEN_OUT         = 7'h19,
    OP_PEN_STORE       = 7'h1a,
    OP_PEN_PUSH        = 7'h1b,
    OP_PEN_POP         = 7'h1c,
    OP_SET_ACTIVITY    = 7'h1d,
    OP_SET_LISTEN      = 7'h1e,
    OP_CALL            = 7'h1f,
    OP_RETURN          = 7'h20,
    OP_CLIP_CTRL       = 7'h21,
    OP_PICK_CTRL       = 7'h22,
    OP_DEF_BRUSH       = 7'h23,
    OP_AA_DIST         = 7'h24,
    OP_CHIP_POS        = 7'h25,
    OP_STACK_BND       = 7'h26,
    OP_SIGNAL          = 7'h27,
    OP_STORE_IMM_CUR   = 7'h28,
    OP_JUMP            = 7'h29,
    OP_INQUIRE         = 7'h2a,
    OP_MOVE_PEN        = 7'h2b,
    OP_STRING          = 7'h2c,
    OP_ARC             = 7'h2d,
    OP_CIRCLE          = 7'h2e,
    OP_LINE            = 7'h2f,
    OP_POINT           = 7'h30,
    OP_FRECT           = 7'h31,
    OP_FTRI            = 7'h32,
    OP_FBOUND          = 7'h33,
    OP_FCONN           = 7'h34,
    OP_BIN             = 7'h35,
    OP_BOUT            = 7'h36,
    OP_BCOPY           = 7'h37,
    OP_BXFORM          = 7'h38,
    OP_RESERVED        = 7'h7f
  } op_t;

  // first-word field positions
  localparam int OPC_LSB     = 0;
  localparam int OPC_W       = 8;
  localparam int COMB_LSB    = 8;
  localparam int COMB_W      = 3;
  localparam int EP_BIT      = 11;
  localparam int LS_BIT      = 12;
  localparam int MATCH_BIT   = 13;
  localparam int INV_BIT     = 14;
  localparam int AA_BIT      = 15;

  // cycle budgets
  localparam logic [31:0] CYC_SET_COLOR    = 32'd112;
  localparam logic [31:0] CYC_ARC_OVH      = 32'd573;
  localparam logic [31:0] CYC_ARC_OCTANT   = 32'd54;
  localparam logic [31:0] CYC_ARC_PIXEL    = 32'd15;
  localparam logic [31:0] CYC_VP_UNSCALED  = 32'd15;
  localparam logic [31:0] CYC_VP_SCALED    = 32'd296;
  localparam logic [31:0] CYC_REL_UNSCALED = 32'd20;
  localparam logic [31:0] CYC_REL_SCALED   = 32'd284;
  localparam logic [31:0] CYC_INDIRECT     = 32'd34;
  localparam logic [31:0] CYC_PROG_WORD    = 32'd11;
  localparam logic [3:0]  ARC_PARAMS       = 4'd10;

  // register byte offsets
  localparam logic [7:0] REG_INSTR   = 8'h00;
  localparam logic [7:0] REG_COUNTS  = 8'h04;
  localparam logic [7:0] REG_MODE    = 8'h08;
  localparam logic [7:0] REG_RESULT  = 8'h0c;
  localparam logic [7:0] REG_BUDGET  = 8'h10;
  localparam logic [7:0] REG_FLAGS   = 8'h14;
  localparam logic [7:0] REG_PEN     = 8'h18;
  localparam logic [7:0] REG_ENDPT   = 8'h1c;

  localparam logic [1:0] AM_ABS      = 2'd0;
  localparam logic [1:0] AM_VIEWPORT = 2'd1;
  localparam logic [1:0] AM_RELATIVE = 2'd2;

  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

endpackage

/* File: verilog/opcode_map.sv */
// combinational opcode-to-operation map
`timescale 1ns/1ps
module opcode_map (
  input  wire logic [7:0]       opcode_in,
  output opcode_pkg::op_t       op_out,
  output logic                  reserved_out
);

  always_comb begin
    case (opcode_in)
      8'h00: op_out = opcode_pkg::OP_NOP;
      8'h04: op_out = opcode_pkg::OP_STRING_CUR;
      8'h08: op_out = opcode_pkg::OP_ARC_CUR;
      8'h0a: op_out = opcode_pkg::OP_CIRCLE_CUR;
      8'h0c: op_out = opcode_pkg::OP_LINE_CUR;
      8'h0e: op_out = opcode_pkg::OP_POINT_CUR;
      8'h10: op_out = opcode_pkg::OP_FRECT_CUR;
      8'h12: op_out = opcode_pkg::OP_FTRI_CUR;
      8'h14: op_out = opcode_pkg::OP_FBOUND_CUR;
      8'h16: op_out = opcode_pkg::OP_FCONN_CUR;
      8'h18: op_out = opcode_pkg::OP_BIN_CUR;
      8'h1a: op_out = opcode_pkg::OP_BOUT_CUR;
      8'h1c: op_out = opcode_pkg::OP_BCOPY_CUR;
      8'h1e: op_out = opcode_pkg::OP_BXFORM_CUR;
      8'h20: op_out = opcode_pkg::OP_SET_COLOR;
      8'h21: op_out = opcode_pkg::OP_SET_SEARCH;
      8'h22: op_out = opcode_pkg::OP_SET_BLOCK;
      8'h23: op_out = opcode_pkg::OP_FONT_CUR;
      8'h24: op_out = opcode_pkg::OP_CLIP_BND_CUR;
      8'h25: op_out = opcode_pkg::OP_LINE_STYLE;
      8'h26: op_out = opcode_pkg::OP_STYLE_PHASE;
      8'h27: op_out = opcode_pkg::OP_VIEWPORT_CUR;
      8'h28: op_out = opcode_pkg::OP_PICK_REG_CUR;
      8'h29: op_out = opcode_pkg::OP_SCALE;
      8'h2a: op_out = opcode_pkg::OP_PEN_OUT;
      8'h2b: op_out = opcode_pkg::OP_PEN_STORE;
      8'h2c: op_out = opcode_pkg::OP_PEN_PUSH;
      8'h2d: op_out = opcode_pkg::OP_PEN_POP;
      8'h30: op_out = opcode_pkg::OP_SET_ACTIVITY;
      8'h31: op_out = opcode_pkg::OP_SET_LISTEN;
      8'h32: op_out = opcode_pkg::OP_CALL;
      8'h33: op_out = opcode_pkg::OP_RETURN;
      8'h34: op_out = opcode_pkg::OP_CLIP_CTRL;
      8'h35: op_out = opcode_pkg::OP_PICK_CTRL;
      8'h36: op_out = opcode_pkg::OP_DEF_BRUSH;
      8'h37: op_out = opcode_pkg::OP_AA_DIST;
      8'h38: op_out = opcode_pkg::OP_CHIP_POS;
      8'h39: op_out = opcode_pkg::OP_STACK_BND;
      8'h3a: op_out = opcode_pkg::OP_SIGNAL;
      8'h3b: op_out = opcode_pkg::OP_STORE_IMM_CUR;
      8'h3c: op_out = opcode_pkg::OP_JUMP;
      8'h3f: op_out = opcode_pkg::OP_INQUIRE;
      8'h40: op_out = opcode_pkg::OP_MOVE_PEN;
      8'h44: op_out = opcode_pkg::OP_STRING;
      8'h48: op_out = opcode_pkg::OP_ARC;
      8'h4a: op_out = opcode_pkg::OP_CIRCLE;
      8'h4c: op_out = opcode_pkg::OP_LINE;
      8'h4e: op_out = opcode_pkg::OP_POINT;
      8'h50: op_out = opcode_pkg::OP_FRECT;
      8'h52: op_out = opcode_pkg::OP_FTRI;
      8'h54: op_out = opcode_pkg::OP_FBOUND;
      8'h56: op_out = opcode_pkg::OP_FCONN;
      8'h58: op_out = opcode_pkg::OP_BIN;
      8'h5a: op_out = opcode_pkg::OP_BOUT;
      8'h5c: op_out = opcode_pkg::OP_BCOPY;
      8'h5e: op_out = opcode_pkg::OP_BXFORM;
      default: op_out = opcode_pkg::OP_RESERVED;
    endcase
    reserved_out = (op_out == opcode_pkg::OP_RESERVED);
  end

endmodule

/* File: verilog/opcode_decoder.sv */
// opcode decoder with cycle-budget model and AHB-Lite register slave
`timescale 1ns/1ps
// Function
// - codes 10,12,14,16: pen-relative rectangle, triangle, bounded and connected fills
// - codes 18,1A,1C,1E: pen-relative block input, output, copy, transform
// - codes 23,24,27,28: pen-relative font base, clip boundary, viewport, pick region
// - codes 25,26,29: line style, line style phase, scale factor
// - codes 2A-2D: output, store, push, pop pen position
// - codes 36-39: brush pattern, anti-alias distance, chip position, stack bounds
// - 32,33,34,35,3A,3B,3C,3F system control ops; 00 is no operation
// - codes 40-4E explicit draws; 50,52,54 explicit fills
// - colour-bit load always costs exactly 112 cycles
// - explicit arc: 573 overhead, 54 per octant, 15 per pixel
// - quoted counts are absolute-mode baseline; other modes add costs
// - each pair adds 15 viewport unscaled, 296 viewport scaled
// - each pair adds 20 relative unscaled, 284 relative scaled
// - each indirection level adds 34 cycles
// - stored-program fetch adds 11 cycles per instruction word
// - anti-alias bit: anti-alias if brush off, brush source if brush on
// - invert bit inverts brush pattern, only when brush enabled
// - word bits 7:0 opcode, then 3-bit combine op, then flags
// - after an arc the pen position becomes the arc end point
module opcode_decoder (
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  output logic             dispatch_out,
  output logic      [6:0]  operation_out,
  output logic             reserved_out,
  output logic             antialias_en_out,
  output logic             pattern_source_out,
  output logic             pattern_invert_out,
  output logic             match_only_out,
  output logic             line_style_select_out,
  output logic             endpoint_draw_mode_out,
  output logic      [2:0]  combine_op_select_out,
  output logic      [31:0] cycle_budget_out,
  output logic      [31:0] pen_position_out
);

  opcode_pkg::op_t  map_op;
  logic             map_rsv;
  logic             wr_pend_q;
  logic             rd_pend_q;
  logic [7:0]       addr_q;
  logic [15:0]      instr_q;
  logic [15:0]      octants_q;
  logic [15:0]      pixels_q;
  logic [1:0]       addr_mode_q;
  logic             scaled_q;
  logic [3:0]       pairs_q;
  logic [3:0]       indirect_q;
  logic             prog_mode_q;
  logic             brush_en_q;
  logic [3:0]       words_q;
  logic [31:0]      endpt_q;
  logic             issue_q;
  logic [31:0]      base_d;
  logic [31:0]      mode_d;
  logic [31:0]      budget_d;
  logic [31:0]      pair_cost;

  opcode_map u_map (
    .opcode_in    (instr_q[opcode_pkg::OPC_LSB +: opcode_pkg::OPC_W]),
    .op_out       (map_op),
    .reserved_out (map_rsv)
  );

  // bus address phase capture
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= 8'h00;
    end else if (hready_in) begin
      wr_pend_q <= hsel_in && htrans_in[1] && hwrite_in;
      rd_pend_q <= hsel_in && htrans_in[1] && !hwrite_in;
      addr_q    <= haddr_in[7:0];
    end
  end

  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;

  // register writes; writing the instruction word issues it
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      instr_q     <= 16'h0000;
      octants_q   <= 16'h0000;
      pixels_q    <= 16'h0000;
      addr_mode_q <= opcode_pkg::AM_ABS;
      scaled_q    <= 1'b0;
      pairs_q     <= 4'h0;
      indirect_q  <= 4'h0;
      prog_mode_q <= 1'b0;
      brush_en_q  <= 1'b0;
      words_q     <= 4'h1;
      endpt_q     <= 32'h0000_0000;
      issue_q     <= 1'b0;
    end else begin
      issue_q <= 1'b0;
      if (wr_pend_q) begin
        case (addr_q)
          opcode_pkg::REG_INSTR: begin
            instr_q <= hwdata_in[15:0];
            issue_q <= 1'b1;
          end
          opcode_pkg::REG_COUNTS: begin
            octants_q <= hwdata_in[15:0];
            pixels_q  <= hwdata_in[31:16];
          end
          opcode_pkg::REG_MODE: begin
            addr_mode_q <= hwdata_in[1:0];
            scaled_q    <= hwdata_in[2];
            prog_mode_q <= hwdata_in[3];
            brush_en_q  <= hwdata_in[4];
            pairs_q     <= hwdata_in[11:8];
            indirect_q  <= hwdata_in[15:12];
            words_q     <= hwdata_in[19:16];
          end
          opcode_pkg::REG_ENDPT: endpt_q <= hwdata_in;
          default: ;
        endcase
      end
    end
  end

  // addressing-mode cost per operand pair
  always_comb begin
    case (addr_mode_q)
      opcode_pkg::AM_VIEWPORT:
        pair_cost = scaled_q ? opcode_pkg::CYC_VP_SCALED
                             : opcode_pkg::CYC_VP_UNSCALED;
      opcode_pkg::AM_RELATIVE:
        pair_cost = scaled_q ? opcode_pkg::CYC_REL_SCALED
                             : opcode_pkg::CYC_REL_UNSCALED;
      default: pair_cost = 32'h0000_0000;
    endcase
  end

  // baseline cost for absolute addressing
  always_comb begin
    case (map_op)
      opcode_pkg::OP_SET_COLOR: base_d = opcode_pkg::CYC_SET_COLOR;
      opcode_pkg::OP_ARC:
        base_d = opcode_pkg::CYC_ARC_OVH
               + opcode_pkg::CYC_ARC_OCTANT * {16'h0000, octants_q}
               + opcode_pkg::CYC_ARC_PIXEL * {16'h0000, pixels_q};
      default: base_d = 32'h0000_0000;
    endcase
  end

  // mode adders; the colour-bit load stays at its fixed count
  always_comb begin
    mode_d = pair_cost * {28'h0000000, pairs_q}
           + opcode_pkg::CYC_INDIRECT * {28'h0000000, indirect_q};
    if (prog_mode_q) begin
      mode_d = mode_d + opcode_pkg::CYC_PROG_WORD * {28'h0000000, words_q};
    end
    if (map_op == opcode_pkg::OP_SET_COLOR || map_rsv) begin
      mode_d = 32'h0000_0000;
    end
    budget_d = base_d + mode_d;
  end

  // decode results on issue
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      dispatch_out           <= 1'b0;
      operation_out          <= opcode_pkg::OP_NONE;
      reserved_out           <= 1'b0;
      antialias_en_out       <= 1'b0;
      pattern_source_out     <= 1'b0;
      pattern_invert_out     <= 1'b0;
      match_only_out         <= 1'b0;
      line_style_select_out  <= 1'b0;
      endpoint_draw_mode_out <= 1'b0;
      combine_op_select_out  <= 3'h0;
      cycle_budget_out       <= 32'h0000_0000;
    end else begin
      dispatch_out <= issue_q && !map_rsv;
      if (issue_q) begin
        operation_out          <= map_op;
        reserved_out           <= map_rsv;
        antialias_en_out       <= instr_q[opcode_pkg::AA_BIT] && !brush_en_q;
        pattern_source_out     <= instr_q[opcode_pkg::AA_BIT] && brush_en_q;
        pattern_invert_out     <= instr_q[opcode_pkg::INV_BIT] && brush_en_q;
        match_only_out         <= instr_q[opcode_pkg::MATCH_BIT] && brush_en_q;
        line_style_select_out  <= instr_q[opcode_pkg::LS_BIT];
        endpoint_draw_mode_out <= instr_q[opcode_pkg::EP_BIT];
        combine_op_select_out  <= instr_q[opcode_pkg::COMB_LSB +: opcode_pkg::COMB_W];
        cycle_budget_out       <= budget_d;
      end
    end
  end

  // pen position follows the arc end point
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      pen_position_out <= 32'h0000_0000;
    end else if (issue_q && (map_op == opcode_pkg::OP_ARC
                             || map_op == opcode_pkg::OP_ARC_CUR)) begin
      pen_position_out <= endpt_q;
    end
  end

  // read mux
  always_comb begin
    case (addr_q)
      opcode_pkg::REG_INSTR:  hrdata_out = {16'h0000, instr_q};
      opcode_pkg::REG_COUNTS: hrdata_out = {pixels_q, octants_q};
      opcode_pkg::REG_MODE:   hrdata_out = {12'h000, words_q, indirect_q, pairs_q,
                                            3'h0, brush_en_q, prog_mode_q, scaled_q,
                                            addr_mode_q};
      opcode_pkg::REG_RESULT: hrdata_out = {16'h0000, 4'h0, opcode_pkg::ARC_PARAMS,
                                            reserved_out, operation_out};
      opcode_pkg::REG_BUDGET: hrdata_out = cycle_budget_out;
      opcode_pkg::REG_FLAGS:  hrdata_out = {23'h000000, combine_op_select_out,
                                            endpoint_draw_mode_out, line_style_select_out,
                                            match_only_out, pattern_invert_out,
                                            pattern_source_out, antialias_en_out};
      opcode_pkg::REG_PEN:    hrdata_out = pen_position_out;
      opcode_pkg::REG_ENDPT:  hrdata_out = endpt_q;
      default:                hrdata_out = 32'h0000_0000;
    endcase
    if (!rd_pend_q) begin
      hrdata_out = 32'h0000_0000;
    end
  end

endmodule

/* File: sim/opcode_decoder_assertions.sv */
// checker for the opcode decoder output ports
`timescale 1ns/1ps
module opcode_decoder_checker (
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic        dispatch_out,
  input  wire logic [6:0]  operation_out,
  input  wire logic        reserved_out,
  input  wire logic        antialias_en_out,
  input  wire logic        pattern_source_out,
  input  wire logic        pattern_invert_out,
  input  wire logic        match_only_out,
  input  wire logic [31:0] cycle_budget_out,
  input  wire logic [31:0] pen_position_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);

  a_aa_exclusive:
    assert property (!(antialias_en_out && pattern_source_out))
    else $error("antialias and pattern source set together");
  a_invert_brush:
    assert property (pattern_invert_out |-> !antialias_en_out)
    else $error("invert set while brush disabled");
  a_match_brush:
    assert property (match_only_out |-> !antialias_en_out)
    else $error("match set while brush disabled");
  a_color_budget:
    assert property (dispatch_out && operation_out == opcode_pkg::OP_SET_COLOR
                     |-> cycle_budget_out == 32'h0000_0070)
    else $error("colour load budget not 112");
  a_arc_floor:
    assert property (dispatch_out && operation_out == opcode_pkg::OP_ARC
                     |-> cycle_budget_out >= 32'h0000_023d)
    else $error("arc budget below overhead");
  a_pen_hold:
    assert property (dispatch_out && !(operation_out inside {opcode_pkg::OP_ARC,
                     opcode_pkg::OP_ARC_CUR}) |-> $stable(pen_position_out))
    else $error("pen moved by a non-arc operation");
  a_pen_steady:
    assert property (!dispatch_out |-> $stable(pen_position_out))
    else $error("pen moved without an issue");
  a_dispatch_valid:
    assert property (dispatch_out |-> !reserved_out && operation_out != opcode_pkg::OP_NONE
                     && operation_out != opcode_pkg::OP_RESERVED)
    else $error("dispatch for a reserved code");
  a_reserved_budget:
    assert property (reserved_out |-> cycle_budget_out == 32'h0000_0000)
    else $error("reserved code carries a budget");
endmodule

bind opcode_decoder opcode_decoder_checker u_chk (
  .clk_in(clk_in), .reset_in(reset_in), .dispatch_out(dispatch_out),
  .operation_out(operation_out), .reserved_out(reserved_out),
  .antialias_en_out(antialias_en_out), .pattern_source_out(pattern_source_out),
  .pattern_invert_out(pattern_invert_out), .match_only_out(match_only_out),
  .cycle_budget_out(cycle_budget_out), .pen_position_out(pen_position_out)
);

/* File: sim/host_model.sv */
// bus master model of the host issuing words to the decoder
`timescale 1ns/1ps
module host_model (
  input  wire logic        clk_in,
  input  wire logic        hready_in,
  input  wire logic [31:0] hrdata_in,
  output logic             hsel_out,
  output logic      [31:0] haddr_out,
  output logic      [1:0]  htrans_out,
  output logic             hwrite_out,
  output logic      [2:0]  hsize_out,
  output logic      [31:0] hwdata_out
);
  logic        rdy_q;
  logic [31:0] rd_q;

  initial begin
    hsel_out = 1'b0;
    haddr_out = 32'h0;
    htrans_out = 2'b00;
    hwrite_out = 1'b0;
    hsize_out = 3'b010;
    hwdata_out = 32'h0;
  end

  always @(posedge clk_in) begin
    rdy_q <= hready_in;
    rd_q  <= hrdata_in;
  end

  task automatic wait_ready();
    do begin
      @(posedge clk_in);
      #1;
    end while (rdy_q !== 1'b1);
  endtask

  // one single word transfer; idle address and data lines show the inverse of their last value
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata);
    hsel_out   <= 1'b1;
    haddr_out  <= {24'h0, addr};
    htrans_out <= 2'b10;
    hwrite_out <= wr;
    hsize_out  <= 3'b010;
    wait_ready();
    hsel_out   <= 1'b0;
    htrans_out <= 2'b00;
    haddr_out  <= ~haddr_out;
    hwdata_out <= wr ? wdata : ~hwdata_out;
    wait_ready();
    rdata = rd_q;
    hwdata_out <= ~hwdata_out;
  endtask
endmodule

/* File: sim/tb_opcode_decoder.sv */
// self-checking bench for the opcode decoder
`timescale 1ns/1ps
module tb_opcode_decoder;
  logic        clk_in;
  logic        reset_in;
  logic        hsel, hwrite, hready, hresp, dispatch, reserved;
  logic        aa, ps, inv, match, ls, ep;
  logic [1:0]  htrans;
  logic [2:0]  hsize, comb;
  logic [6:0]  operation;
  logic [31:0] haddr, hwdata, hrdata, budget, pen;
  int          err_total;
  int          n_checks;
  int          cyc;

  host_model u_host (.clk_in(clk_in), .hready_in(hready), .hrdata_in(hrdata),
    .hsel_out(hsel), .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite),
    .hsize_out(hsize), .hwdata_out(hwdata));

  opcode_decoder u_dut (.clk_in(clk_in), .reset_in(reset_in), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
    .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
    .hresp_out(hresp), .dispatch_out(dispatch), .operation_out(operation),
    .reserved_out(reserved), .antialias_en_out(aa), .pattern_source_out(ps),
    .pattern_invert_out(inv), .match_only_out(match), .line_style_select_out(ls),
    .endpoint_draw_mode_out(ep), .combine_op_select_out(comb),
    .cycle_budget_out(budget), .pen_position_out(pen));

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      end_sim();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    u_host.xfer(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    u_host.xfer(1'b0, a, 32'h0, d);
  endtask

  // write an instruction word and step to the cycle where dispatch stands
  task automatic issue(input logic [15:0] w);
    wr(opcode_pkg::REG_INSTR, {16'h0, w});
    @(posedge clk_in);
    #1;
  endtask

  function automatic bit is_def(input int c);
    return c == 0 || c == 8'h3f || (c >= 8'h20 && c <= 8'h2d) || (c >= 8'h30 && c <= 8'h3c)
      || (c >= 4 && c <= 8'h5e && c % 2 == 0 && !(c inside {6, 8'h2e, 8'h3e, 8'h42, 8'h46}));
  endfunction

  initial begin
    logic [31:0] r;
    logic [31:0] exp;
    logic [7:0]  f;
    logic [7:0]  fl [4] = '{8'hff, 8'h5a, 8'ha5, 8'he0};
    logic [31:0] md [7] = '{32'h0000_0400, 32'h0000_0401, 32'h0000_0405, 32'h0000_0402,
                            32'h0000_0406, 32'h0000_2000, 32'h000a_0008};
    int          ad [7] = '{0, 4 * 15, 4 * 296, 4 * 20, 4 * 284, 2 * 34, 10 * 11};
    int          rank;
    bit          d;
    err_total = 0;
    n_checks = 0;
    cyc = 0;
    reset_in = 1'b1;
    repeat (20) @(posedge clk_in);
    #1;
    check(operation, opcode_pkg::OP_NONE);
    check({29'h0, hready, hresp, dispatch}, 32'h0000_0004);
    check(budget, 32'h0000_0000);
    reset_in <= 1'b0;
    @(posedge clk_in);
    #1;
    rank = 0;
    for (int c = 0; c < 8'h60; c++) begin
      d = is_def(c);
      issue({8'h00, c[7:0]});
      check(dispatch, d);
      check(reserved, !d);
      if (d) begin
        rank++;
        if (c < 8'h20) check(operation, rank[6:0]);
        else if (c < 8'h30) check(operation, rank[6:0]);
        else if (c < 8'h40) check(operation, rank[6:0]);
        else check(operation, rank[6:0]);
      end
    end
    check(operation, opcode_pkg::OP_RESERVED);
    for (int k = 0; k < 4; k++) begin
      f = fl[k];
      wr(opcode_pkg::REG_MODE, {27'h0, k[0], 4'h0});
      issue({f, 8'h4c});
      exp = {21'h0, f[2:0], 2'b00, f[3], f[4], f[5] & k[0], f[6] & k[0], f[7] & k[0],
             f[7] & ~k[0]};
      check({21'h0, comb, 2'b00, ep, ls, match, inv, ps, aa}, exp);
      rd(opcode_pkg::REG_FLAGS, r);
      check(r, {23'h0, exp[10:8], exp[5:0]});
    end
    wr(opcode_pkg::REG_COUNTS, 32'h0007_0003);
    for (int i = 0; i < 7; i++) begin
      wr(opcode_pkg::REG_MODE, md[i]);
      issue(16'h0048);
      exp = 573 + 3 * 54 + 7 * 15 + ad[i];
      check(budget, exp);
      rd(opcode_pkg::REG_BUDGET, r);
      check(r, exp);
    end
    issue(16'h0020);
    check(budget, 112);
    @(posedge clk_in);
    #1;
    check(dispatch, 1'b0);
    wr(opcode_pkg::REG_ENDPT, 32'h023f_0236);
    issue(16'h0548);
    check(pen, 32'h023f_0236);
    wr(opcode_pkg::REG_ENDPT, 32'h01f4_01f4);
    issue(16'h004c);
    check(pen, 32'h023f_0236);
    issue(16'h0508);
    rd(opcode_pkg::REG_PEN, r);
    check(r, 32'h01f4_01f4);
    rd(opcode_pkg::REG_RESULT, r);
    check(r[11:0], {4'ha, 1'b0, opcode_pkg::OP_ARC_CUR});
    wr(8'h20, 32'h5a5a_a5a5);
    rd(8'h20, r);
    check(r, 32'h0);
    end_sim();
  end
endmodule
